// ### hw/cs_decoder_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of
 * the block chip-select decoder. Assumes a word-indexed register port.
 */
`ifndef CS_DECODER_MAP_SVH
`define CS_DECODER_MAP_SVH

// Register index = base + 4 * block; each block owns four slots
`define CSD_OFF_START      6'h00
`define CSD_OFF_MASK       6'h01
`define CSD_OFF_CTRL_LOW   6'h02
`define CSD_OFF_CTRL_HIGH  6'h03
`define CSD_OFF_STATUS     6'h18
`define CSD_BLOCK_STRIDE   3'h4

// Control high fields
`define CSD_HI_ENABLE      7
`define CSD_HI_RANGE_MODE  6
`define CSD_HI_TYPE_LSB    2
`define CSD_HI_WIDTH_LSB   0
// Control low fields
`define CSD_LO_WRITE_LSB   4
`define CSD_LO_READ_LSB    0

`define CSD_RESET_START    8'h00
`define CSD_RESET_MASK     8'h00
`define CSD_RESET_LOW      8'h22
`define CSD_RESET_HIGH     8'h00

// Least bus cycle in wait-pin mode, in states
`define CSD_MIN_STATES     3'h2

`endif

// ### hw/cs_decoder_pkg.sv
/*
 * Types shared by the block chip-select decoder.
 * Assumes the map header is included alongside.
 */
`default_nettype none
package cs_decoder_pkg;
    typedef enum logic [1:0] {
        WIDTH8  = 2'h0,
        WIDTH16 = 2'h1,
        WIDTH32 = 2'h2
    } bus_width_t;

    typedef enum logic [1:0] {
        MEM_SRAM = 2'h0,
        MEM_DRAM = 2'h2
    } mem_type_t;

    typedef struct packed {
        logic       req;
        logic       write;
        logic [23:0] addr;
    } cpu_req_t;

    typedef struct packed {
        logic [5:0] block_chip_select_n;
        logic [1:0] width;
        logic       dram;
        logic       pageRom;
        logic       busy;
        logic       done;
    } bus_out_t;
endpackage
`default_nettype wire

// ### hw/block_chip_select_decoder.sv
/*
 * Six-area chip-select decoder with per-block width, type and wait control.
 * Assumes the CPU holds its request until done and that internal I/O and
 * memory hits are flagged by the CPU side on the same clock.
 */
// What this block does
// R1 - Six block areas 0 to 5, each with start address and size.
// R2 - DRAM type only accepted for blocks 1 and 3.
// R3 - SRAM/ROM runs normal cycle; DRAM hands off to DRAM controller.
// R4 - ROM page mode flagged only for block 2.
// R5 - Each block has its own 8, 16 or 32-bit width.
// R6 - Separate read/write waits: 0 to 3 fixed, or wait pin.
// R7 - Boot pins sampled at reset release pick the start width.
// R8 - Afterwards width comes only from each block's width field.
// R9 - After reset only block 2 active, whole space, boot width.
// R10 - Software programs start and mask, then control with enable.
// R11 - Address compared with start, masked bits skipped, chip select low.
// R12 - Start bits map to A23..A16, 64 Kbyte aligned.
// R13 - Mask bit 0 compares, 1 excludes.
// R14 - Maskable: block 0 A20..A16, block 1 A21..A8, others A22..A15.
// R15 - Block 1 one mask bit covers A15..A9; A23, A22 always compared.
// R16 - Blocks 2 to 5 always compare A23.
// R17 - Block 2 range mode 0 whole space, 1 decoded normally.
// R18 - Priority internal I/O, internal memory, then blocks 0 to 5.
// R19 - Unmatched access goes to block 2 settings and chip select.
// R20 - Type field 00 SRAM/ROM, 10 DRAM, others reserved.
// R21 - Width field 00 8-bit, 01 16-bit, 10 32-bit.
// R22 - Wait-pin cycle at least 2 states, stretched while wait low.
// R23 - Chip select only during active cycle of enabled hit block, or of block 2 (enabled or not) when none hits.
// R24 - Software keeps excluded mask bits contiguous from the bottom.
`include "cs_decoder_map.svh"
`default_nettype none
module block_chip_select_decoder
    import cs_decoder_pkg::*;
#(
    parameter int BLOCKS = 6
)(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Register port
    input  wire logic [5:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output var  logic [7:0]  regRdata,
    // CPU bus request
    input  wire cpu_req_t    cpuReq,
    input  wire logic        internalHit,
    // Pins
    input  wire logic        boot_width_sel_hi,
    input  wire logic        boot_width_sel_lo,
    input  wire logic        waitN,
    // Memory side
    output var  bus_out_t    busOut
);

    typedef enum logic [1:0] {
        IDLE   = 2'h0,
        ACCESS = 2'h1,
        FINISH = 2'h2
    } state_t;

    logic [7:0] startQ [BLOCKS];
    logic [7:0] maskQ  [BLOCKS];
    logic [7:0] lowQ   [BLOCKS];
    logic [7:0] highQ  [BLOCKS];

    // Pin synchronisers
    logic [1:0] bootMeta;
    logic [1:0] bootSync;
    logic       waitMeta;
    logic       waitSync;
    logic       bootTakenQ;
    logic [1:0] bootWidthQ;

    always_ff @(posedge clk)
    begin
        bootMeta <= {boot_width_sel_hi, boot_width_sel_lo};
        bootSync <= bootMeta;
        waitMeta <= waitN;
        waitSync <= waitMeta;
    end

    // R7 sample boot pins
    // Caught one cycle after release, once the synchroniser holds pin state
    always_ff @(posedge clk)
    begin
        if (!rstn)
            bootTakenQ <= 1'b0;
        else
            bootTakenQ <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            bootWidthQ <= 2'h0;
        else if (!bootTakenQ)
            bootWidthQ <= (bootSync == 2'h3) ? 2'h0 : bootSync;
    end

    // Register decode
    logic [2:0] selBlock;
    logic [1:0] selSlot;
    logic       selValid;
    assign selBlock = regAddr[4:2];
    assign selSlot  = regAddr[1:0];
    assign selValid = (regAddr < `CSD_OFF_STATUS);

    logic       busyQ;
    logic [5:0] csQ;

    // Read data; unmapped addresses read zero
    logic [7:0] rdMux;
    assign rdMux = (regAddr == `CSD_OFF_STATUS) ? {busyQ, 1'b0, csQ} :
                   !selValid ? 8'h00 :
                   (selSlot == 2'(`CSD_OFF_START))    ? startQ[selBlock] :
                   (selSlot == 2'(`CSD_OFF_MASK))     ? maskQ[selBlock]  :
                   (selSlot == 2'(`CSD_OFF_CTRL_LOW)) ? lowQ[selBlock]   :
                                                        highQ[selBlock];

    always_ff @(posedge clk)
    begin
        if (!rstn)
            regRdata <= 8'h00;
        else if (regRead)
            regRdata <= rdMux;
    end

    // Per-block registers and comparators
    logic [BLOCKS-1:0] hit;
    logic [1:0]        blkWidth [BLOCKS];

    genvar b;
    generate
        for (b = 0; b < BLOCKS; b++)
        begin : gBlk
            logic        wrHere;
            logic [23:8] careBits;
            logic [1:0]  typeIn;
            assign wrHere = regWrite && selValid && (selBlock == 3'(b));
            // R2 DRAM restricted
            // R20 type encoding
            assign typeIn = (regWdata[`CSD_HI_TYPE_LSB +: 2] == MEM_DRAM && (b == 1 || b == 3))
                            ? MEM_DRAM : MEM_SRAM;

            // R10 programmed registers
            always_ff @(posedge clk)
            begin
                if (!rstn)
                begin
                    startQ[b] <= `CSD_RESET_START;
                    maskQ[b]  <= `CSD_RESET_MASK;
                    lowQ[b]   <= `CSD_RESET_LOW;
                    // R9 only block 2 enabled at reset
                    highQ[b]  <= (b == 2) ? 8'h80 : `CSD_RESET_HIGH;
                end
                else
                begin
                    if (wrHere && selSlot == 2'(`CSD_OFF_START))
                        startQ[b] <= regWdata;
                    if (wrHere && selSlot == 2'(`CSD_OFF_MASK))
                        maskQ[b] <= regWdata;
                    if (wrHere && selSlot == 2'(`CSD_OFF_CTRL_LOW))
                        lowQ[b] <= regWdata;
                    if (wrHere && selSlot == 2'(`CSD_OFF_CTRL_HIGH))
                        highQ[b] <= {regWdata[7], (b == 2) ? regWdata[6] : 1'b0,
                                     2'h0, typeIn,
                                     (regWdata[1:0] == 2'h3) ? 2'h0 : regWdata[1:0]};
                    // R9 boot width into block 2
                    else if (b == 2 && !bootTakenQ)
                        highQ[b][`CSD_HI_WIDTH_LSB +: 2] <=
                            (bootSync == 2'h3) ? 2'h0 : bootSync;
                end
            end

            // R8 width from control field
            assign blkWidth[b] = highQ[b][`CSD_HI_WIDTH_LSB +: 2];

            // R13 mask 1 excludes
            // R14 maskable ranges
            // R15 block 1 grouped bit
            // R16 A23 always compared
            if (b == 0)
            begin : gM0
                // A15..A8 have no mask bit here, so they always take part
                assign careBits = {2'h3, 1'b1, ~maskQ[b][4:0], 8'hFF};
            end
            else if (b == 1)
            begin : gM1
                assign careBits = {2'h3, ~maskQ[b][7:2], {7{~maskQ[b][1]}}, ~maskQ[b][0]};
            end
            else
            begin : gMn
                assign careBits = {1'b1, ~maskQ[b][7:0], 7'h00};
            end

            // R11 compare
            // R12 start on A23..A16
            // R17 range mode
            assign hit[b] = highQ[b][`CSD_HI_ENABLE] &&
                ((b == 2 && !highQ[b][`CSD_HI_RANGE_MODE]) ||
                 ((((cpuReq.addr[23:8] ^ {startQ[b], 8'h00}) & careBits)) == 16'h0000));
        end
    endgenerate

    // R18 priority encode
    // R19 unmatched to block 2
    logic [2:0] winner;
    always_comb
    begin
        winner = 3'h2;
        for (int i = BLOCKS - 1; i >= 0; i--)
            if (hit[i])
                winner = 3'(i);
    end

    // Wait selection
    logic [2:0] waitCode;
    logic       pinMode;
    logic [2:0] fixedStates;
    assign waitCode = cpuReq.write ? lowQ[winner][`CSD_LO_WRITE_LSB +: 3]
                                   : lowQ[winner][`CSD_LO_READ_LSB +: 3];
    // R6 wait codes
    assign pinMode = (waitCode == 3'h3);
    assign fixedStates = (waitCode == 3'h1) ? 3'h2 :
                         (waitCode == 3'h5) ? 3'h4 :
                         (waitCode == 3'h6) ? 3'h5 : 3'h3;

    state_t     stateQ;
    state_t     stateD;
    logic [2:0] cntQ;
    logic [2:0] targetQ;
    logic       pinQ;
    logic       endNow;
    // R22 minimum two states then wait pin
    assign endNow = pinQ ? (cntQ >= `CSD_MIN_STATES - 3'h1 && waitSync)
                         : (cntQ >= targetQ - 3'h1);

    always_comb
    begin
        stateD = stateQ;
        case (stateQ)
            IDLE:
                if (cpuReq.req && !internalHit)
                    stateD = ACCESS;
            ACCESS:
                if (endNow)
                    stateD = FINISH;
            FINISH:
                stateD = IDLE;
            default:
                stateD = IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            stateQ  <= IDLE;
            cntQ    <= 3'h0;
            targetQ <= 3'h3;
            pinQ    <= 1'b0;
        end
        else
        begin
            stateQ <= stateD;
            cntQ   <= (stateQ == ACCESS && !endNow && cntQ != 3'h7) ? cntQ + 3'h1 : 3'h0;
            if (stateQ == IDLE)
            begin
                targetQ <= fixedStates;
                pinQ    <= pinMode;
            end
        end
    end

    // R23 chip select during cycle only
    // R3 DRAM bypasses ordinary strobe
    // R4 page mode only on block 2
    logic       dramSel;
    logic [2:0] winQ;
    assign dramSel = (highQ[winner][`CSD_HI_TYPE_LSB +: 2] == MEM_DRAM);

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            csQ    <= 6'h00;
            busyQ  <= 1'b0;
            winQ   <= 3'h2;
            busOut <= '{block_chip_select_n: 6'h3F, width: 2'h0, dram: 1'b0, pageRom: 1'b0,
                        busy: 1'b0, done: 1'b0};
        end
        else
        begin
            if (stateQ == IDLE && stateD == ACCESS)
            begin
                winQ         <= winner;
                csQ          <= dramSel ? 6'h00 : 6'(6'h01 << winner);
                // R5 per-block width
                busOut.width <= blkWidth[winner];
                busOut.dram  <= dramSel;
                busOut.pageRom <= (winner == 3'h2) && !dramSel;
            end
            else if (stateD == IDLE)
                csQ <= 6'h00;
            busOut.block_chip_select_n  <= (stateD == ACCESS) ?
                           ~((stateQ == IDLE) ? (dramSel ? 6'h00 : 6'(6'h01 << winner)) : csQ)
                           : 6'h3F;
            busOut.busy <= (stateD == ACCESS);
            busyQ       <= (stateD == ACCESS);
            busOut.done <= (stateQ == ACCESS) && endNow;
        end
    end

endmodule
`default_nettype wire

// ### test/cs_decoder_monitor.sv
/* Concurrent checks on the decoder's CPU and memory-side ports.
   Assumes one clock and a synchronous active-low reset. */
`default_nettype none
module cs_decoder_monitor
    import cs_decoder_pkg::*;
(
    // Clock and reset
    input wire logic     clk,
    input wire logic     rstn,
    // Watched ports
    input wire cpu_req_t cpuReq,
    input wire logic     internalHit,
    input wire bus_out_t busOut
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    property p_one_cs;
        $onehot0(~busOut.block_chip_select_n);
    endproperty
    a_one_cs: assert property (p_one_cs) else $error("two selects low");
    property p_cs_in_cycle;
        busOut.block_chip_select_n != 6'h3F |-> busOut.busy;
    endproperty
    a_cs_in_cycle: assert property (p_cs_in_cycle) else $error("select idle");
    property p_done_ends;
        busOut.done |-> busOut.block_chip_select_n == 6'h3F && !busOut.busy;
    endproperty
    a_done_ends: assert property (p_done_ends) else $error("done busy");
    property p_done_pulse;
        busOut.done |=> !busOut.done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done long");
    property p_start_cause;
        $rose(busOut.busy) |-> $past(cpuReq.req) && !$past(internalHit);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("bad start");
    property p_min_states;
        $rose(busOut.busy) |-> busOut.busy[*2];
    endproperty
    a_min_states: assert property (p_min_states) else $error("short cycle");
    property p_fell_done;
        $fell(busOut.busy) |-> busOut.done;
    endproperty
    a_fell_done: assert property (p_fell_done) else $error("end no done");
    property p_internal;
        internalHit && !busOut.busy && !busOut.done |=> !busOut.busy;
    endproperty
    a_internal: assert property (p_internal) else $error("internal hit ran");
    property p_page_blk2;
        busOut.pageRom && busOut.busy |-> !busOut.block_chip_select_n[2];
    endproperty
    a_page_blk2: assert property (p_page_blk2) else $error("page off block");
    property p_dram_no_cs;
        busOut.dram && busOut.busy |-> busOut.block_chip_select_n == 6'h3F;
    endproperty
    a_dram_no_cs: assert property (p_dram_no_cs) else $error("dram with select");
endmodule
bind block_chip_select_decoder cs_decoder_monitor i_cs_decoder_monitor (
    .clk(clk), .rstn(rstn), .cpuReq(cpuReq), .internalHit(internalHit), .busOut(busOut));
`default_nettype wire

// ### test/wait_responder.sv
/* Slow memory part driving the shared wait pin.
   Assumes active-low chip selects and a pulled-up wait line. */
`default_nettype none
module wait_responder
(
    // Clock
    input  wire logic       clk,
    // Memory side
    input  wire logic [5:0] block_chip_select_n,
    input  wire logic [7:0] holdCycles,
    output var  logic       waitN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] selCnt_q = 8'h00;
    // stretch then release
    // Held from before select so the synchroniser already sees it
    always_comb
        waitN = !(holdCycles != 8'h00 && selCnt_q < holdCycles);
    always_ff @(posedge clk)
        selCnt_q <= (&block_chip_select_n) ? 8'h00 : selCnt_q + 8'h01;
endmodule
`default_nettype wire

// ### test/testbench.sv
/* Self-checking bench for the block chip-select decoder.
   Assumes the package and design are compiled first. */
`default_nettype none
module testbench
    import cs_decoder_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [5:0] cs; logic [1:0] w; int lo; int hi;} note_t;
    localparam logic [2:0] CODES [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
    logic       clk = 1'b0, rstn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic [5:0] regAddr = 6'h00;
    logic [7:0] regWdata = 8'h00, regRdata, holdCycles = 8'h00;
    cpu_req_t   cpuReq = '0;
    logic       internalHit = 1'b0, bootHi = 1'b0, bootLo = 1'b1, waitN, rdPend = 1'b0;
    bus_out_t   busOut;
    note_t      cycQ [$], seen, note;
    logic [7:0] rdQ [$];
    int         mismatches = 0, num_checks = 0, busyCnt = 0;
    always #10 clk = ~clk;
    block_chip_select_decoder i_block_chip_select_decoder (.clk(clk), .rstn(rstn),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .cpuReq(cpuReq), .internalHit(internalHit),
        .boot_width_sel_hi(bootHi), .boot_width_sel_lo(bootLo), .waitN(waitN), .busOut(busOut));
    wait_responder i_wait_responder (.clk(clk), .block_chip_select_n(busOut.block_chip_select_n), .holdCycles(holdCycles),
        .waitN(waitN));
    task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic rg(bit wr, logic [5:0] a, logic [7:0] d);
        @(posedge clk);
        regWrite <= wr;
        regRead <= !wr;
        regAddr <= a;
        regWdata <= d;
        if (!wr)
            rdQ.push_back(d);
        @(posedge clk);
        regWrite <= 1'b0;
        regRead <= 1'b0;
    endtask
    task automatic cpu(logic [23:0] a, bit wr, logic [5:0] cs, logic [1:0] w, int lo, int hi);
        int i;
        cycQ.push_back('{cs, w, lo, hi});
        @(posedge clk);
        cpuReq <= '{1'b1, wr, a};
        for (i = 0; i < 60 && busOut.done !== 1'b1; i++)
            @(posedge clk);
        if (i == 60)
        begin
            mismatches++;
            tally_and_finish();
        end
        cpuReq.req <= 1'b0;
        @(posedge clk);
    endtask
    // Result watcher: oldest note against what the outputs show
    always @(posedge clk)
    begin
        if (rdPend)
            chk("regRdata", regRdata, rdQ.pop_front());
        rdPend = regRead;
        busyCnt = busOut.busy ? busyCnt + 1 : busyCnt;
        if (busOut.busy && busyCnt == 1)
            seen = '{busOut.block_chip_select_n, busOut.width, 0, 0};
        if (busOut.done)
        begin
            note = cycQ.pop_front();
            chk("csN", seen.cs, note.cs);
            chk("width", seen.w, note.w);
            chk("states", busyCnt >= note.lo && busyCnt <= note.hi, 1);
            busyCnt = 0;
        end
    end
    initial
    begin
        int k;
        logic [7:0] r;
        void'($urandom(21646));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        chk("csIdle", busOut.block_chip_select_n, 6'h3F);
        @(posedge clk);
        cpu(24'($urandom()), 1'b0, 6'h3B, 2'h1, 3, 3);
        bootHi <= 1'b1;
        bootLo <= 1'b0;
        rg(1'b0, 6'h0B, 8'h81);
        rg(1'b0, 6'h0A, 8'h22);
        rg(1'b0, 6'h1F, 8'h00);
        r = 8'($urandom());
        rg(1'b1, 6'h10, r);
        rg(1'b0, 6'h10, r);
        rg(1'b1, 6'h03, 8'h88);
        rg(1'b0, 6'h03, 8'h80);
        rg(1'b1, 6'h07, 8'h8A);
        rg(1'b0, 6'h07, 8'h8A);
        // Block 0 256 bytes and block 1 512 bytes, both at 110000
        rg(1'b1, 6'h00, 8'h11);
        rg(1'b1, 6'h04, 8'h11);
        rg(1'b1, 6'h05, 8'h01);
        rg(1'b1, 6'h06, 8'h11);
        rg(1'b1, 6'h07, 8'h82);
        cpu(24'h110100, 1'b0, 6'h3D, 2'h2, 2, 2);
        cpu(24'h110200, 1'b1, 6'h3B, 2'h1, 3, 3);
        for (k = 0; k < 4; k++)
        begin
            rg(1'b1, 6'h02, {1'b0, CODES[(k + 1) % 4], 1'b0, CODES[k]});
            cpu(24'h1100FF, 1'b0, 6'h3E, 2'h0, k + 2, k + 2);
            cpu(24'h110000, 1'b1, 6'h3E, 2'h0, (k + 1) % 4 + 2, (k + 1) % 4 + 2);
        end
        rg(1'b1, 6'h02, 8'h33);
        holdCycles <= 8'h06;
        cpu(24'h110000, 1'b0, 6'h3E, 2'h0, 5, 11);
        holdCycles <= 8'h00;
        // Block 2 narrowed to FF0000; block 3 staged before enable
        rg(1'b1, 6'h08, 8'hFF);
        rg(1'b1, 6'h0B, 8'hC1);
        rg(1'b1, 6'h0D, 8'hFF);
        cpu(24'h7F1234, 1'b0, 6'h3B, 2'h1, 3, 3);
        rg(1'b1, 6'h0F, 8'h80);
        cpu(24'h7F1234, 1'b0, 6'h37, 2'h0, 3, 3);
        cpu(24'h801234, 1'b0, 6'h3B, 2'h1, 3, 3);
        // Block 1 switched to DRAM: no chip select drops
        rg(1'b1, 6'h07, 8'h8A);
        cpu(24'h110100, 1'b0, 6'h3F, 2'h2, 2, 2);
        internalHit <= 1'b1;
        cpuReq <= '{1'b1, 1'b0, 24'h110000};
        repeat (4) @(posedge clk);
        chk("busyHit", busOut.busy, 1'b0);
        cpuReq.req <= 1'b0;
        internalHit <= 1'b0;
        repeat (4) @(posedge clk);
        chk("pending", cycQ.size() + rdQ.size(), 0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
